// file: rtl/sta_l1_fsm.sv
// Layer 1 activation state machine with its AHB-Lite register file
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - After reset hold F0/G0, send INFO 0.
// - Writing load bit zero releases the machine.
// - Network release moves G0 to G1.
// - Terminal release moves F0 to F2.
// - Network sends INFO 0/2/4 per state.
// - Network activate or INFO 1 enters G2.
// - Deactivate or T1 expiry enters G4, T2 runs.
// - INFO 0 or lost framing drops G3 to G2; INFO 0 drops G4 to G1.
// - INFO 3 alone never leaves G2.
// - G2 to G3 needs write or auto enable.
// - Terminal sends INFO 0 or INFO 3.
// - Activate F3 to F4; unknown signal to F5.
// - Software T3 expiry returns F4/F5/F8 to F3.
// - INFO 2 with sync enters F6.
// - INFO 4 enters F7.
// - INFO 0 returns F2/F6/F7/F8 to F3.
// - INFO 0 in F6 reaches F3 quickly.
// - Lost sync in F6/F7 enters F8.
module sta_l1_fsm
  import sta_pkg::*;
#(
  parameter int unsigned FRAME_CYC = FRAME_CYCLES,
  parameter int unsigned N_FRAMES = T2_FRAMES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire sta_rx_t rx_ind,
  output sta_info_t tx_info,
  output sta_state_t l1_state
);

  // Offsets are byte addresses; bits above 7 are not decoded
  // Register match on a captured byte offset
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    reg_hit = (a == off);
  endfunction

  // Bus front end outputs
  logic rd_stb;
  sta_wreq_t wreq;

  // All state resets asynchronously to the held F0/G0 state
  // Control and status state
  sta_state_t state_q; // current Fx or Gx number
  sta_state_t state_d;
  logic held_q; // machine frozen by load bit
  logic te_mode_q; // terminal mode when set
  logic auto_g2g3_q; // permanent G2 to G3 permission
  logic g2g3_permit_q; // one-shot G2 to G3 permission
  logic info0_seen_q; // INFO 0 seen while in F6
  logic t1_exp_q; // software T1 expiry pulse
  logic t3_exp_q; // software T3 expiry pulse
  logic t2_start; // starts the guard timer
  logic t2_exp; // guard timer done
  logic take_g3; // G2 to G3 step taken

  // Decoded writes of this data phase
  logic wr_state;
  logic wr_ctrl1;
  logic wr_timer;
  logic load_req; // write with load bit high
  logic release_req; // write with load bit low while held
  logic act_req; // activate command
  logic deact_req; // deactivate command

  // hsize is always a whole word here; narrower writes still store the low bits
  logic unused_size;
  assign unused_size = ^hsize;

  // Address phase capture; writes are delayed by one cycle
  // so that hwdata already stands when they are decoded
  sta_ahb_front u_front (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .rd_stb(rd_stb),
    .wreq(wreq)
  );

  // Guard timer for G4; cancelled whenever the machine leaves G4
  // by another route, so a stale expiry can never fire later
  // Terminal mode never uses it
  sta_t2_timer #(
    .FRAME_CYC(FRAME_CYC),
    .N_FRAMES(N_FRAMES)
  ) u_t2 (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(t2_start),
    .cancel(state_q != STA_S4 || te_mode_q),
    .expire(t2_exp)
  );

  // Write decode
  // A release is only a release while held; the same pattern
  // on a running machine is an ordinary command write
  assign wr_state = wreq.wr & reg_hit(wreq.addr, OFF_STATE_WR);
  assign wr_ctrl1 = wreq.wr & reg_hit(wreq.addr, OFF_CTRL1);
  assign wr_timer = wreq.wr & reg_hit(wreq.addr, OFF_TIMER_EV);
  assign load_req = wr_state & hwdata[WR_LOAD_BIT];
  assign release_req = wr_state & ~hwdata[WR_LOAD_BIT] & held_q;
  assign act_req = wr_state & ~hwdata[WR_LOAD_BIT] & (hwdata[WR_ACT_LSB +: 2] == ACT_ACTIVATE);
  assign deact_req = wr_state & ~hwdata[WR_LOAD_BIT] & (hwdata[WR_ACT_LSB +: 2] == ACT_DEACTIVATE);

  // Bus handshake: zero wait states, always OKAY
  // No wait state is ever needed: every register is a flop
  // and every write completes in its own data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read data captured in the address phase; unmapped offsets read zero
  // Limitation: a read right behind a write sees the old value
  // Reading state_read_reg also clears info0_seen_flag below
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= HRDATA_RESET;
    end else if (rd_stb) begin
      hrdata <= HRDATA_RESET;
      if (reg_hit(haddr[7:0], OFF_STATE_RD)) begin
        hrdata[WR_STATE_LSB +: 4] <= state_q;
        hrdata[RD_INFO0_BIT] <= info0_seen_q;
        hrdata[RD_HELD_BIT] <= held_q;
        hrdata[RD_TE_BIT] <= te_mode_q;
        hrdata[RD_TX_LSB +: 3] <= tx_info;
      end else if (reg_hit(haddr[7:0], OFF_CTRL1)) begin
        hrdata[C1_AUTO_G2G3_BIT] <= auto_g2g3_q;
        hrdata[C1_TE_MODE_BIT] <= te_mode_q;
      end
    end
  end

  // Line control register
  // Change the mode only while held: the state number is kept
  // across a mode change and means something else after it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auto_g2g3_q <= 1'b0;
      te_mode_q <= 1'b0;
    end else if (wr_ctrl1) begin
      auto_g2g3_q <= hwdata[C1_AUTO_G2G3_BIT];
      te_mode_q <= hwdata[C1_TE_MODE_BIT];
    end
  end

  // Software timer expiries arrive as one-cycle pulses
  // T1 and T3 live in software; writing a one is the expiry.
  // Registering it costs one cycle of latency but keeps
  // the timer bits of hwdata off the next-state path
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t1_exp_q <= 1'b0;
      t3_exp_q <= 1'b0;
    end else begin
      t1_exp_q <= wr_timer & hwdata[EV_T1_BIT];
      t3_exp_q <= wr_timer & hwdata[EV_T3_BIT];
    end
  end

  // One-shot G2 to G3 permission; a new write wins over consumption
  // Each write with set_g2_to_g3 allows one step; a repeat before that step adds none
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      g2g3_permit_q <= 1'b0;
    end else if (wr_state & hwdata[WR_SET_G2G3_BIT]) begin
      g2g3_permit_q <= 1'b1;
    end else if (take_g3) begin
      g2g3_permit_q <= 1'b0;
    end
  end

  // INFO 0 seen in F6: set wins over the clear-on-read
  // Lets software spot a short detour from F6 through F3
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      info0_seen_q <= 1'b0;
    end else if (te_mode_q && !held_q && state_q == STA_S6 && rx_ind.info0) begin
      info0_seen_q <= 1'b1;
    end else if (rd_stb && reg_hit(haddr[7:0], OFF_STATE_RD)) begin
      info0_seen_q <= 1'b0;
    end
  end

  // Hold flag: set at reset and by a load, cleared by release
  // A load always holds, so software can park the machine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_q <= 1'b1;
    end else if (load_req) begin
      held_q <= 1'b1;
    end else if (release_req) begin
      held_q <= 1'b0;
    end
  end

  // G2 to G3 only with INFO 3 and a permission
  // Terminal mode never takes this path
  assign take_g3 = !held_q && !te_mode_q && state_q == STA_S2 && rx_ind.info3 &&
                   (g2g3_permit_q || auto_g2g3_q);

  // Next state; line events are ignored while held
  // Priority: a register load beats everything, then the hold,
  // then line, timer and command events per mode
  always_comb begin
    state_d = state_q;
    t2_start = 1'b0;
    if (load_req) begin
      state_d = sta_state_t'(hwdata[WR_STATE_LSB +: 4]);
    end else if (held_q) begin
      // Frozen: only the release may move the reset state
      if (release_req && state_q == STA_S0) begin
        state_d = te_mode_q ? STA_S2 : STA_S1;
      end
    end else if (!te_mode_q) begin
      // Network side states G0 to G4
      // Activate in G2 or G3 is ignored: already activating
      case (state_q)
        STA_S0, STA_S1: begin
          if (act_req || (state_q == STA_S1 && rx_ind.info1)) begin
            state_d = STA_S2;
          end
        end
        STA_S2: begin
          if (deact_req || t1_exp_q) begin
            state_d = STA_S4;
            t2_start = 1'b1;
          end else if (take_g3) begin
            state_d = STA_S3;
          end
        end
        STA_S3: begin
          if (deact_req) begin
            state_d = STA_S4;
            t2_start = 1'b1;
          end else if (rx_ind.info0 || rx_ind.lost_frame) begin
            state_d = STA_S2;
          end
        end
        STA_S4: begin
          if (act_req) begin
            state_d = STA_S2;
          end else if (t2_exp || rx_ind.info0) begin
            state_d = STA_S1;
          end
        end
        default: state_d = STA_S0;
      endcase
    end else if (deact_req) begin
      // Terminal deactivation from any state
      // Software should not deactivate from F6 or F7
      state_d = STA_S3;
    end else begin
      // Terminal side states F0 to F8
      // Receive events first, then timers, then commands
      case (state_q)
        // F0 only leaves through the release or the deactivation above
        STA_S0: state_d = STA_S0;
        STA_S2, STA_S3, STA_S4, STA_S5, STA_S6, STA_S7, STA_S8: begin
          if (rx_ind.info4 && state_q != STA_S7) begin
            state_d = STA_S7;
          end else if (rx_ind.info2 && state_q != STA_S6) begin
            state_d = STA_S6;
          end else if (rx_ind.info0 && (state_q == STA_S2 || state_q == STA_S6 ||
                                        state_q == STA_S7 || state_q == STA_S8)) begin
            state_d = STA_S3;
          end else if (rx_ind.lost_frame && (state_q == STA_S6 || state_q == STA_S7)) begin
            state_d = STA_S8;
          end else if (rx_ind.any_sig && (state_q == STA_S3 || state_q == STA_S4)) begin
            state_d = STA_S5;
          end else if (t3_exp_q && (state_q == STA_S4 || state_q == STA_S5 || state_q == STA_S8)) begin
            state_d = STA_S3;
          end else if (act_req && state_q == STA_S3) begin
            state_d = STA_S4;
          end
        end
        default: state_d = STA_S0;
      endcase
    end
  end

  // State register
  // Updates on the same edge as l1_state, so both always agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= STA_S0;
    end else begin
      state_q <= state_d;
    end
  end

  // Transmitted INFO and visible state, both from flops
  // Both follow the next state, so the line signal and the
  // visible state change on one edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_info <= STA_INFO0;
      l1_state <= STA_S0;
    end else begin
      l1_state <= state_d;
      if (!te_mode_q) begin
        case (state_d)
          STA_S2: tx_info <= STA_INFO2;
          STA_S3: tx_info <= STA_INFO4;
          default: tx_info <= STA_INFO0;
        endcase
      end else begin
        case (state_d)
          STA_S6, STA_S7: tx_info <= STA_INFO3;
          default: tx_info <= STA_INFO0;
        endcase
      end
    end
  end

endmodule // sta_l1_fsm
`default_nettype wire

// file: rtl/sta_pkg.sv
// Shared constants, types and register map of the layer 1 activation block
package sta_pkg;

  // Clock and frame timing
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned FRAME_NS = 125000;
  localparam int unsigned FRAME_CYCLES = FRAME_NS * CLK_MHZ / 1000;
  localparam int unsigned T2_FRAMES = 256;

  // Register byte offsets
  localparam logic [7:0] OFF_STATE_WR = 8'h00;
  localparam logic [7:0] OFF_STATE_RD = 8'h04;
  localparam logic [7:0] OFF_CTRL1 = 8'h08;
  localparam logic [7:0] OFF_TIMER_EV = 8'h0C;

  // state_write_reg fields
  localparam int WR_STATE_LSB = 0;
  localparam int WR_LOAD_BIT = 4;
  localparam int WR_ACT_LSB = 5;
  localparam int WR_SET_G2G3_BIT = 7;
  // state_read_reg fields
  localparam int RD_INFO0_BIT = 4;
  localparam int RD_HELD_BIT = 5;
  localparam int RD_TE_BIT = 6;
  localparam int RD_TX_LSB = 8;
  // line_control_1 fields
  localparam int C1_AUTO_G2G3_BIT = 0;
  localparam int C1_TE_MODE_BIT = 1;
  // timer event register fields (write one to signal expiry)
  localparam int EV_T1_BIT = 0;
  localparam int EV_T3_BIT = 1;

  // Activation command field codes
  localparam logic [1:0] ACT_DEACTIVATE = 2'h2;
  localparam logic [1:0] ACT_ACTIVATE = 2'h3;

  // AHB transfer type bit that marks NONSEQ/SEQ
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic [31:0] HRDATA_RESET = 32'h0000_0000;

  // State number, Fx in terminal mode, Gx in network mode
  typedef enum logic [3:0] {
    STA_S0 = 4'h0, STA_S1 = 4'h1, STA_S2 = 4'h2, STA_S3 = 4'h3, STA_S4 = 4'h4,
    STA_S5 = 4'h5, STA_S6 = 4'h6, STA_S7 = 4'h7, STA_S8 = 4'h8
  } sta_state_t;

  // Transmitted INFO signal
  typedef enum logic [2:0] {
    STA_INFO0 = 3'h0, STA_INFO1 = 3'h1, STA_INFO2 = 3'h2, STA_INFO3 = 3'h3, STA_INFO4 = 3'h4
  } sta_info_t;

  // Receive indications from the line data path
  typedef struct packed {
    logic info0;
    logic info1;
    logic info2;
    logic info3;
    logic info4;
    logic any_sig;
    logic lost_frame;
  } sta_rx_t;

  // Bus request as seen by the register file
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
  } sta_wreq_t;

endpackage

// file: rtl/sta_ahb_front.sv
// AHB-Lite address phase capture for the layer 1 register file
`timescale 1ns/1ps
`default_nettype none
module sta_ahb_front
  import sta_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic rd_stb,
  output sta_wreq_t wreq
);

  // Transfer accepted this address phase
  logic take;

  assign take = hsel & hready & htrans[HTRANS_ACTIVE_BIT];
  // Reads are answered from the address phase, data flop stands in the data phase
  assign rd_stb = take & ~hwrite;

  // Writes land in the data phase, when hwdata is valid
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wreq <= '0;
    end else begin
      wreq.wr <= take & hwrite;
      wreq.addr <= haddr[7:0];
    end
  end

endmodule // sta_ahb_front
`default_nettype wire

// file: rtl/sta_t2_timer.sv
// Deactivation guard timer counting whole frame periods
`timescale 1ns/1ps
`default_nettype none
module sta_t2_timer
  import sta_pkg::*;
#(
  parameter int unsigned FRAME_CYC = FRAME_CYCLES,
  parameter int unsigned N_FRAMES = T2_FRAMES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic cancel,
  output logic expire
);

  // Cycle counter inside one frame, and frame counter
  logic [23:0] cyc_q;
  logic [9:0] frm_q;
  logic run_q;

  // Restart wins over cancel so a new deactivation is never lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q <= 1'b0;
      cyc_q <= '0;
      frm_q <= '0;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (start) begin
        run_q <= 1'b1;
        cyc_q <= '0;
        frm_q <= '0;
      end else if (cancel) begin
        run_q <= 1'b0;
      end else if (run_q) begin
        if (cyc_q == 24'(FRAME_CYC - 1)) begin
          cyc_q <= '0;
          if (frm_q == 10'(N_FRAMES - 1)) begin
            run_q <= 1'b0;
            expire <= 1'b1;
          end else begin
            frm_q <= frm_q + 10'h001;
          end
        end else begin
          cyc_q <= cyc_q + 24'h000001;
        end
      end
    end
  end

endmodule // sta_t2_timer
`default_nettype wire

// file: verif/sta_l1_properties.sv
// Concurrent checks on the ports of the layer 1 activation block
`timescale 1ns/1ps
`default_nettype none
module sta_l1_properties
  import sta_pkg::*;
#(
  parameter int unsigned FRAME_CYC = FRAME_CYCLES,
  parameter int unsigned N_FRAMES = T2_FRAMES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire sta_rx_t rx_ind,
  input wire sta_info_t tx_info,
  input wire sta_state_t l1_state
);
  logic wd_q; // Write data phase in progress
  logic [7:0] wa_q; // Byte offset of that write
  logic te_q; // Mirror of the terminal mode bit
  logic auto_q; // Mirror of the automatic G3 permission
  logic pend_q; // One-shot G3 permission not yet used
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Mirror control writes; a write lands only in its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_q <= 1'b0;
      wa_q <= 8'h00;
      te_q <= 1'b0;
      auto_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      wd_q <= hsel && hready && htrans[HTRANS_ACTIVE_BIT] && hwrite;
      wa_q <= haddr[7:0];
      if (wd_q && wa_q == OFF_CTRL1) begin
        te_q <= hwdata[C1_TE_MODE_BIT];
        auto_q <= hwdata[C1_AUTO_G2G3_BIT];
      end
      // Cleared on reaching G3, so one write permits one step
      if (l1_state == STA_S3) begin
        pend_q <= 1'b0;
      end else if (wd_q && wa_q == OFF_STATE_WR && hwdata[WR_SET_G2G3_BIT]) begin
        pend_q <= 1'b1;
      end
    end
  end
  // Leaving G4 without a write in between
  sequence s_g4_exit;
    !te_q && !wd_q && l1_state == STA_S4 ##1 l1_state != STA_S4;
  endsequence
  property p_hold;
    l1_state == STA_S0 && !wd_q |=> l1_state == STA_S0;
  endproperty
  property p_nt_tx;
    !te_q |-> tx_info == (l1_state == STA_S2 ? STA_INFO2 : l1_state == STA_S3 ? STA_INFO4 : STA_INFO0);
  endproperty
  property p_te_tx;
    te_q |-> tx_info == (l1_state inside {STA_S6, STA_S7} ? STA_INFO3 : STA_INFO0);
  endproperty
  property p_nt_perm;
    !te_q && !auto_q && !pend_q && !wd_q && l1_state == STA_S2 |=> l1_state != STA_S3;
  endproperty
  property p_g3_drop;
    !te_q && !wd_q && l1_state == STA_S3 && (rx_ind.info0 || rx_ind.lost_frame) |=> l1_state == STA_S2;
  endproperty
  property p_g4_exit;
    s_g4_exit |-> l1_state inside {STA_S1, STA_S2};
  endproperty
  property p_te_info4;
    te_q && !wd_q && rx_ind.info4 && l1_state inside {STA_S2, STA_S3, STA_S4, STA_S5, STA_S6, STA_S8}
      |=> l1_state == STA_S7;
  endproperty
  property p_te_info0;
    te_q && !wd_q && rx_ind.info0 && !rx_ind.info2 && !rx_ind.info4
      && l1_state inside {STA_S2, STA_S6, STA_S7, STA_S8} |=> l1_state == STA_S3;
  endproperty
  a_hold: assert property (p_hold) else $error("left reset state unreleased");
  a_nt_tx: assert property (p_nt_tx) else $error("wrong network signal");
  a_te_tx: assert property (p_te_tx) else $error("wrong terminal signal");
  a_nt_perm: assert property (p_nt_perm) else $error("G3 without permission");
  a_g3_drop: assert property (p_g3_drop) else $error("G3 did not drop to G2");
  a_g4_exit: assert property (p_g4_exit) else $error("bad exit from G4");
  a_te_info4: assert property (p_te_info4) else $error("INFO 4 did not reach F7");
  a_te_info0: assert property (p_te_info0) else $error("INFO 0 did not reach F3");
endmodule // sta_l1_properties
bind sta_l1_fsm sta_l1_properties #(.FRAME_CYC(FRAME_CYC), .N_FRAMES(N_FRAMES)) u_props (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .rx_ind, .tx_info, .l1_state
);
`default_nettype wire

// file: verif/sta_remote.sv
// Remote line party model feeding receive indications
`timescale 1ns/1ps
`default_nettype none
module sta_remote
  import sta_pkg::*;
#(
  parameter int unsigned DLY = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [2:0] sig,
  input wire logic lost,
  input wire logic obey,
  input wire sta_info_t tx_info,
  output sta_rx_t rx_ind
);
  int unsigned cnt_q; // Cycles of network silence heard
  // Falls silent DLY cycles after the network stops, well inside T2
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 0;
    end else if (obey && sig == 3'h3 && tx_info == STA_INFO0) begin
      cnt_q <= (cnt_q < DLY) ? cnt_q + 1 : cnt_q;
    end else begin
      cnt_q <= 0;
    end
  end
  // Code 5 is an unidentified signal, 7 nothing recognised
  always_comb begin
    rx_ind = '0;
    rx_ind.lost_frame = lost;
    if (cnt_q == DLY) begin
      rx_ind.info0 = 1'b1;
    end else begin
      rx_ind.info0 = (sig == 3'h0);
      rx_ind.info1 = (sig == 3'h1);
      rx_ind.info2 = (sig == 3'h2);
      rx_ind.info3 = (sig == 3'h3);
      rx_ind.info4 = (sig == 3'h4);
      rx_ind.any_sig = (sig == 3'h5);
    end
  end
endmodule // sta_remote
`default_nettype wire

// file: verif/test_st_layer1_activation_fsm.sv
// Self-checking bench for the layer 1 activation block
`timescale 1ns/1ps
`default_nettype none
module test_st_layer1_activation_fsm;
  import sta_pkg::*;
  localparam int unsigned FC = 4; // Shortened frame period
  localparam int unsigned NF = 4; // Shortened T2 frame count
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] sig = 3'h7; // Remote starts with nothing recognisable
  logic lost = 1'b0;
  logic obey = 1'b0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  sta_rx_t rx_ind;
  sta_info_t tx_info;
  sta_state_t l1_state;
  logic [31:0] rd; // Last read word
  int fails = 0;
  int checks_done = 0;
  always #5 hclk = ~hclk;
  // Single slave, so its ready is the bus ready
  sta_l1_fsm #(.FRAME_CYC(FC), .N_FRAMES(NF)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .rx_ind, .tx_info, .l1_state);
  sta_remote #(.DLY(5)) u_remote (.hclk, .hresetn, .sig, .lost, .obey, .tx_info, .rx_ind);
  // Word compare
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Line compare: wait up to n cycles for the state, then check it with its signal
  task automatic see(input sta_state_t s, input sta_info_t i, input int n);
    int k;
    k = 0;
    #1;
    while (l1_state !== s && k < n) begin
      @(posedge hclk);
      #1;
      k++;
    end
    cmp({25'h0, l1_state, tx_info}, {25'h0, s, i});
  endtask
  // One single transfer; returns at the data phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // What the remote party sends
  task automatic line(input logic [2:0] s, input logic l, input logic o);
    @(posedge hclk);
    sig <= s;
    lost <= l;
    obey <= o;
  endtask
  task automatic t_reset();
    see(STA_S0, STA_INFO0, 0);
    line(3'h1, 1'b0, 1'b0);
    repeat (4) @(posedge hclk);
    see(STA_S0, STA_INFO0, 0);
    bus(1'b0, OFF_STATE_RD, 32'h0);
    cmp(rd, 32'h0000_0020);
    bus(1'b0, 8'h10, 32'h0);
    cmp({rd[30:0], hresp}, 32'h0);
    cmp({30'h0, hreadyout, hresp}, 32'h2);
  endtask
  task automatic t_nt_up();
    bus(1'b1, OFF_STATE_WR, 32'h0);
    see(STA_S1, STA_INFO0, 0);
    see(STA_S2, STA_INFO2, 1);
    line(3'h3, 1'b0, 1'b1);
    repeat (8) @(posedge hclk);
    see(STA_S2, STA_INFO2, 0);
    bus(1'b1, OFF_STATE_WR, 32'h0000_0080);
    see(STA_S3, STA_INFO4, 2);
    bus(1'b1, OFF_STATE_WR, 32'h0000_0040);
    see(STA_S4, STA_INFO0, 0);
    see(STA_S1, STA_INFO0, 10);
  endtask
  task automatic t_nt_t2();
    int n;
    line(3'h1, 1'b0, 1'b0);
    see(STA_S2, STA_INFO2, 2);
    bus(1'b1, OFF_CTRL1, 32'h1);
    line(3'h3, 1'b0, 1'b0);
    see(STA_S3, STA_INFO4, 3);
    line(3'h7, 1'b1, 1'b0);
    see(STA_S2, STA_INFO2, 2);
    bus(1'b1, OFF_TIMER_EV, 32'h1);
    see(STA_S4, STA_INFO0, 1);
    line(3'h3, 1'b0, 1'b0);
    n = 0;
    while (l1_state === STA_S4 && n < 100) begin
      @(posedge hclk);
      #1;
      n++;
    end
    cmp({31'h0, n >= FC * (NF - 1) - 2 && n <= FC * NF + 2}, 32'h1);
    see(STA_S1, STA_INFO0, 0);
    bus(1'b1, OFF_STATE_WR, 32'h0000_0060);
    see(STA_S2, STA_INFO2, 0);
    see(STA_S3, STA_INFO4, 2);
  endtask
  task automatic t_te();
    line(3'h7, 1'b0, 1'b0);
    bus(1'b1, OFF_STATE_WR, 32'h0000_0010);
    see(STA_S0, STA_INFO0, 0);
    bus(1'b1, OFF_CTRL1, 32'h2);
    bus(1'b0, OFF_CTRL1, 32'h0);
    cmp(rd, 32'h0000_0002);
    bus(1'b1, OFF_STATE_WR, 32'h0);
    see(STA_S2, STA_INFO0, 0);
    line(3'h2, 1'b0, 1'b0);
    see(STA_S6, STA_INFO3, 2);
    line(3'h4, 1'b0, 1'b0);
    see(STA_S7, STA_INFO3, 2);
    line(3'h7, 1'b1, 1'b0);
    see(STA_S8, STA_INFO0, 2);
    line(3'h2, 1'b0, 1'b0);
    see(STA_S6, STA_INFO3, 2);
    line(3'h0, 1'b0, 1'b0);
    see(STA_S3, STA_INFO0, 2);
    bus(1'b0, OFF_STATE_RD, 32'h0);
    cmp(rd, 32'h0000_0053);
    line(3'h7, 1'b0, 1'b0);
    bus(1'b1, OFF_STATE_WR, 32'h0000_0060);
    see(STA_S4, STA_INFO0, 0);
    line(3'h5, 1'b0, 1'b0);
    see(STA_S5, STA_INFO0, 2);
    bus(1'b1, OFF_TIMER_EV, 32'h2);
    see(STA_S3, STA_INFO0, 1);
  endtask
  // Verdict and end of run
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Main sequence after a 20 cycle reset
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_nt_up();
    t_nt_t2();
    t_te();
    complete_run();
  end
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    complete_run();
  end
endmodule // test_st_layer1_activation_fsm
`default_nettype wire
